/* src/dmp_map.svh */
// Constants for the dual modulus prescaler
// Contract
// - Divide by ten whenever any of the five modulus gate inputs is high.
// - Divide by eleven only when all five modulus gate inputs are low.
// - Sample the combined modulus control only at the edge taken in counter state 1100.
// - An open TTL gate input counts as high and an open ECL gate input counts as low.
// - Wider modulus pairs come from cascading external stages on the same select path.
`ifndef DMP_MAP_SVH
`define DMP_MAP_SVH
`define DMP_CNT_W 4
`define DMP_DECIDE_STATE 4'h0c
`define DMP_START_STATE 4'h4
`define DMP_LAST_DIV10 4'h0d
`define DMP_LAST_DIV11 4'h0e
`define DMP_DIV_LO 10
`define DMP_DIV_HI 11
`define DMP_HALF_POINT 4'h9
`endif

/* src/dmp_pkg.sv */
// Types for the dual modulus prescaler
package dmp_pkg;
  typedef enum logic [1:0] {
    DMP_MOD_10 = 2'b01,
    DMP_MOD_11 = 2'b10
  } dmp_mod_t;
endpackage

/* src/dmp_gate_if.sv */
// Modulus gate bundle between top and combiner
interface dmp_gate_if;
  logic [2:0] ecl_gate;
  logic [1:0] ttl_gate;
  logic [1:0] ttl_open;
  logic [2:0] ecl_open;
  logic mod_ten;
  modport src (output ecl_gate, output ttl_gate, output ttl_open, output ecl_open,
    input mod_ten);
  modport comb (input ecl_gate, input ttl_gate, input ttl_open, input ecl_open,
    output mod_ten);
endinterface

/* src/dmp_gate_comb.sv */
// Combines the five modulus gate inputs into one divide-by-ten request
module dmp_gate_comb (
  dmp_gate_if.comb gif
);
  logic [1:0] ttl_eff;
  logic [2:0] ecl_eff;
  assign ttl_eff = gif.ttl_gate | gif.ttl_open;
  assign ecl_eff = gif.ecl_gate & ~gif.ecl_open;
  assign gif.mod_ten = (|ttl_eff) | (|ecl_eff);
endmodule

/* src/dmp_prescaler.sv */
// Dual modulus divide by ten or eleven prescaler
`include "dmp_map.svh"
module dmp_prescaler (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_modulus_gate_ecl_a,
  input wire logic i_modulus_gate_ecl_b,
  input wire logic i_modulus_gate_ecl_c,
  input wire logic i_modulus_gate_ttl_a,
  input wire logic i_modulus_gate_ttl_b,
  input wire logic [2:0] i_ecl_open,
  input wire logic [1:0] i_ttl_open,
  output logic o_div_out,
  output logic o_cycle_pulse,
  output logic o_mod_eleven
);
  dmp_gate_if gif ();
  logic [`DMP_CNT_W-1:0] cnt_reg;
  logic [`DMP_CNT_W-1:0] cnt_next;
  dmp_pkg::dmp_mod_t mod_reg;
  logic [`DMP_CNT_W-1:0] last_state;

  // Final counter state for the chosen modulus
  function automatic logic [`DMP_CNT_W-1:0] dmp_last_of(input logic ten);
    if (ten) begin
      return `DMP_LAST_DIV10;
    end else begin
      return `DMP_LAST_DIV11;
    end
  endfunction

  assign gif.ecl_gate = {i_modulus_gate_ecl_c, i_modulus_gate_ecl_b, i_modulus_gate_ecl_a};
  assign gif.ttl_gate = {i_modulus_gate_ttl_b, i_modulus_gate_ttl_a};
  assign gif.ecl_open = i_ecl_open;
  assign gif.ttl_open = i_ttl_open;

  dmp_gate_comb u_comb (
    .gif(gif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Modulus decision
  // Sample only in 1100
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mod_reg <= dmp_pkg::DMP_MOD_10;
    end else if (cnt_reg == `DMP_DECIDE_STATE) begin
      mod_reg <= gif.mod_ten ? dmp_pkg::DMP_MOD_10 : dmp_pkg::DMP_MOD_11;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter
  // Decision sets current cycle end
  always_comb begin
    if (cnt_reg == `DMP_DECIDE_STATE) begin
      last_state = dmp_last_of(gif.mod_ten);
    end else begin
      last_state = dmp_last_of(mod_reg == dmp_pkg::DMP_MOD_10);
    end
  end

  // Count runs 4..last; decision at 1100 lies inside every cycle
  always_comb begin
    if (cnt_reg == last_state || cnt_reg < `DMP_START_STATE || cnt_reg > `DMP_LAST_DIV11) begin
      cnt_next = `DMP_START_STATE;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= `DMP_START_STATE;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Cycle pulse feeds external cascade stages
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cycle_pulse <= 1'b0;
      o_div_out <= 1'b0;
      o_mod_eleven <= 1'b0;
    end else begin
      o_cycle_pulse <= (cnt_next == `DMP_START_STATE);
      o_div_out <= (cnt_next >= `DMP_START_STATE) && (cnt_next < `DMP_HALF_POINT);
      o_mod_eleven <= (cnt_reg == `DMP_DECIDE_STATE) ? ~gif.mod_ten
        : (mod_reg == dmp_pkg::DMP_MOD_11);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_decide_ten;
    cnt_reg == `DMP_DECIDE_STATE && gif.mod_ten;
  endsequence
  sequence s_decide_eleven;
    cnt_reg == `DMP_DECIDE_STATE && !gif.mod_ten;
  endsequence
  sequence s_cycle_start;
    cnt_reg == `DMP_START_STATE;
  endsequence
  sequence s_ten_tail;
    (cnt_reg == `DMP_LAST_DIV10) ##1 (cnt_reg == `DMP_START_STATE);
  endsequence
  sequence s_eleven_tail;
    (cnt_reg == `DMP_LAST_DIV10) ##1 (cnt_reg == `DMP_LAST_DIV11) ##1 s_cycle_start;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Cycle length checks
  // Ten cycle tail
  ten_length_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_decide_ten |=> s_ten_tail)
    else $error("divide by ten cycle wrong");

  eleven_length_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_decide_eleven |=> s_eleven_tail)
    else $error("divide by eleven cycle wrong");

  ten_period_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_decide_ten |-> ##10 (cnt_reg == `DMP_DECIDE_STATE))
    else $error("divide by ten period wrong");

  eleven_period_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_decide_eleven |-> ##11 (cnt_reg == `DMP_DECIDE_STATE))
    else $error("divide by eleven period wrong");

  ////////////////////////////////////////////////////////////////////////
  // Decision checks
  // Choice held between decisions
  hold_choice_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $past(cnt_reg) != `DMP_DECIDE_STATE |-> $stable(mod_reg))
    else $error("modulus sampled outside decision state");

  flag_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (cnt_reg != `DMP_DECIDE_STATE) |=> $stable(o_mod_eleven))
    else $error("eleven flag moved outside decision");

  flag_match_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_decide_eleven |=> o_mod_eleven)
    else $error("eleven flag not set");

  flag_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_decide_ten |=> !o_mod_eleven)
    else $error("eleven flag set on divide by ten");

  ////////////////////////////////////////////////////////////////////////
  // Gate combining checks
  // Open TTL reads high
  open_inputs_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (|i_ttl_open) |-> gif.mod_ten)
    else $error("open TTL input not high");

  ecl_open_low_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ((&i_ecl_open) && (gif.ttl_gate == 2'b00) && (i_ttl_open == 2'b00)) |-> !gif.mod_ten)
    else $error("open ECL input not low");

  ttl_high_ten_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (|gif.ttl_gate) |-> gif.mod_ten)
    else $error("high TTL gate not divide by ten");

  all_low_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ((gif.ecl_gate == 3'b000) && (gif.ttl_gate == 2'b00) && (i_ttl_open == 2'b00))
      |-> !gif.mod_ten)
    else $error("all low gates not divide by eleven");

  ////////////////////////////////////////////////////////////////////////
  // Counter and output checks
  // Counter stays in range
  count_range_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    cnt_reg >= `DMP_START_STATE && cnt_reg <= `DMP_LAST_DIV11)
    else $error("counter out of range");

  step_count_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (cnt_reg != last_state) |=> (cnt_reg == $past(cnt_reg) + 4'h1))
    else $error("counter skipped a state");

  wrap_start_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (cnt_reg == last_state) |=> s_cycle_start)
    else $error("counter did not wrap");

  pulse_spacing_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_cycle_pulse) |=> !o_cycle_pulse [*8])
    else $error("output period too short");

  pulse_single_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cycle_pulse |=> !o_cycle_pulse)
    else $error("cycle pulse too long");

  // Pulse returns in ten or eleven
  pulse_rate_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cycle_pulse |-> ##[10:11] o_cycle_pulse)
    else $error("cycle pulse period wrong");

  pulse_at_start_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_cycle_pulse |-> s_cycle_start)
    else $error("cycle pulse off start state");

  pulse_follow_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_cycle_start |-> ##[10:11] s_cycle_start)
    else $error("cycle not restarted");

  div_high_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_div_out |-> (cnt_reg >= `DMP_START_STATE && cnt_reg < `DMP_HALF_POINT))
    else $error("divided output high outside first half");

  div_low_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (cnt_reg >= `DMP_HALF_POINT) |-> !o_div_out)
    else $error("divided output high in second half");
endmodule

/* test/dmp_ctrl_model.sv */
// Partner model: synthesizer control driving the modulus gates
module dmp_ctrl_model (
  input wire logic i_clk,
  input wire logic i_pulse,
  output logic [9:0] o_gates
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'h3540_d103;
  int k = 99;
  logic [9:0] r;
  logic [4:0] q_exp[$];
  initial o_gates = 10'h000;
  // Noise away from decision, final choice held over it
  always @(negedge i_clk) begin
    k = i_pulse ? 0 : k + 1;
    r = 10'($random(seed));
    if (k < 3 || k > 8) o_gates <= r;
    if (k == 3) begin
      if (r[9]) r = 10'h000;
      o_gates <= r;
      // Open TTL reads high, open ECL reads low
      q_exp.push_back(5'd11 - 5'(|(r[2:0] & ~r[7:5]) | |(r[4:3] | r[9:8])));
    end
  end
endmodule

/* test/tb_dual_modulus_prescaler.sv */
// Self-checking bench for the prescaler
module tb_dual_modulus_prescaler;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [9:0] g;
  logic o_div_out, o_cycle_pulse, o_mod_eleven;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hi = 0;
  int ticks = 0;
  bit seen = 0;
  logic [4:0] e;
  always #25 i_mclk = ~i_mclk;
  dmp_ctrl_model u_ctrl (.i_clk(i_mclk), .i_pulse(o_cycle_pulse), .o_gates(g));
  dmp_prescaler DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_modulus_gate_ecl_a(g[0]),
    .i_modulus_gate_ecl_b(g[1]), .i_modulus_gate_ecl_c(g[2]), .i_modulus_gate_ttl_a(g[3]),
    .i_modulus_gate_ttl_b(g[4]), .i_ecl_open(g[7:5]), .i_ttl_open(g[9:8]),
    .o_div_out(o_div_out), .o_cycle_pulse(o_cycle_pulse), .o_mod_eleven(o_mod_eleven));
  task automatic check(input string what, input logic [4:0] sv, input logic [4:0] ev);
    samples_checked++;
    if (sv !== ev) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, ev, sv);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Monitor: period length per pulse against oldest note
  always @(negedge i_mclk) begin
    cyc++;
    hi += (o_div_out === 1'b1);
    if (o_cycle_pulse === 1'b1) begin
      if (seen && u_ctrl.q_exp.size() > 0) begin
        e = u_ctrl.q_exp.pop_front();
        check("period", 5'(cyc), e);
        check("mod_eleven", {4'h0, o_mod_eleven}, e - 5'd10);
        check("div_high", 5'(hi), 5'd5);
      end
      seen = 1;
      cyc = 0;
      hi = 0;
    end
  end
  // Hang guard: pulses must keep coming
  always @(posedge i_mclk) begin
    ticks = o_cycle_pulse ? 0 : ticks + 1;
    if (ticks > 40) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (3000) @(negedge i_mclk);
    finish_test();
  end
endmodule
